// ---- src/dual_buffer_pointer_flow_ctrl.v ----
`timescale 1ns/1ps
`include "seq_ptr_defs.vh"
module dual_buffer_pointer_flow_ctrl (
  input wire core_clk_i,
  input wire rstn_i,
  input wire command_mode_n_i,
  input wire chip_enable_n_i,
  input wire read_write_i,
  input wire [2:0] cmd_addr_i,
  input wire [15:0] host_data_i,
  output reg [15:0] host_data_o,
  output reg host_data_oe_o,
  input wire advance_enable_n_i,
  input wire pointer_load_n_i,
  input wire restart_buf1_n_i,
  input wire restart_buf2_n_i,
  input wire [11:0] seq_load_data_i,
  output reg [11:0] pointer_o,
  output reg buf1_end_flag_n_o,
  output reg buf2_end_flag_n_o,
  output reg seq_write_enable_o
);

  function [11:0] step_addr;
    input [11:0] base;
    input [1:0] amount;
    begin
      step_addr = base + {10'h000, amount};
    end
  endfunction

  // End match, used on the current and on the next pointer value
  function at_end;
    input [11:0] ptr;
    input [11:0] last;
    begin
      at_end = (ptr == last);
    end
  endfunction

  // Host pins are asynchronous to the pointer clock
  wire [21:0] host_raw;
  wire [21:0] host_idle;
  wire [21:0] host_s;
  wire cmd_n_s;
  wire ce_n_s;
  wire rw_s;
  wire [2:0] sel_s;
  wire [15:0] wdata_s;

  assign host_raw = {command_mode_n_i, chip_enable_n_i, read_write_i,
                     cmd_addr_i, host_data_i};
  assign host_idle = {3'h7, 3'h0, 16'h0000};
  assign cmd_n_s = host_s[21];
  assign ce_n_s = host_s[20];
  assign rw_s = host_s[19];
  assign sel_s = host_s[18:16];
  assign wdata_s = host_s[15:0];

  pin_sync2 #(
    .WIDTH(22)
  ) u_host_sync (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .async_i(host_raw),
    .idle_i(host_idle),
    .sync_o(host_s)
  );

  // Block state
  reg [11:0] ptr_q;
  reg [11:0] ptr_d;
  reg [11:0] b1_first_q;
  reg [11:0] b1_first_d;
  reg [11:0] b1_last_q;
  reg [11:0] b1_last_d;
  reg [11:0] b2_first_q;
  reg [11:0] b2_first_d;
  reg [11:0] b2_last_q;
  reg [11:0] b2_last_d;
  reg [1:0] mode1_q;
  reg [1:0] mode1_d;
  reg [1:0] mode2_q;
  reg [1:0] mode2_d;
  reg flag1_q;
  reg flag1_d;
  reg flag2_q;
  reg flag2_d;
  reg halted_q;
  reg halted_d;
  reg [11:0] halt_end_q;
  reg [11:0] halt_end_d;
  reg release_q;
  reg release_d;
  reg load_pend_q;
  reg load_pend_d;
  reg [11:0] load_data_q;
  reg [11:0] load_data_d;
  reg wr_seen_q;

  // Access decode
  wire cmd_active;
  wire wr_level;
  wire wr_stb;
  wire rd_level;
  wire wr_b1_first;
  wire wr_b1_last;
  wire wr_b2_first;
  wire wr_b2_last;
  wire wr_flow;
  wire wr_flags;

  assign cmd_active = ~cmd_n_s & ce_n_s;
  assign wr_level = cmd_active & ~rw_s;
  assign rd_level = cmd_active & rw_s;
  // One write per access, however long the host holds it
  assign wr_stb = wr_level & ~wr_seen_q;
  assign wr_b1_first = wr_stb & (sel_s == `SEL_B1_FIRST);
  assign wr_b1_last = wr_stb & (sel_s == `SEL_B1_LAST);
  assign wr_b2_first = wr_stb & (sel_s == `SEL_B2_FIRST);
  assign wr_b2_last = wr_stb & (sel_s == `SEL_B2_LAST);
  assign wr_flow = wr_stb & (sel_s == `SEL_FLOW);
  assign wr_flags = wr_stb & (sel_s == `SEL_FLAGS);

  // End matches
  wire hit1;
  wire hit2;
  wire advance;
  wire [1:0] hit_mode;

  assign hit1 = at_end(ptr_q, b1_last_q);
  assign hit2 = at_end(ptr_q, b2_last_q);
  assign advance = ~advance_enable_n_i;
  // Buffer one governs when both ends coincide
  assign hit_mode = hit1 ? mode1_q : mode2_q;

  // Flags track the pointer being launched, so a flag shows with its address
  wire hit1_next;
  wire hit2_next;
  assign hit1_next = at_end(ptr_d, b1_last_d);
  assign hit2_next = at_end(ptr_d, b2_last_d);

  wire [15:0] rdata;

  cmd_readback u_readback (
    .sel_i(sel_s),
    .b1_first_i(b1_first_q),
    .b1_last_i(b1_last_q),
    .b2_first_i(b2_first_q),
    .b2_last_i(b2_last_q),
    .mode1_i(mode1_q),
    .mode2_i(mode2_q),
    .halted_i(halted_q),
    .flag1_i(flag1_q),
    .flag2_i(flag2_q),
    .rdata_o(rdata)
  );

  // Boundary and mode registers
  always @* begin
    b1_first_d = b1_first_q;
    b1_last_d = b1_last_q;
    b2_first_d = b2_first_q;
    b2_last_d = b2_last_q;
    mode1_d = mode1_q;
    mode2_d = mode2_q;
    if (wr_b1_first) begin
      b1_first_d = wdata_s[`ADDR_MSB:0];
    end
    if (wr_b1_last) begin
      b1_last_d = wdata_s[`ADDR_MSB:0];
    end
    if (wr_b2_first) begin
      b2_first_d = wdata_s[`ADDR_MSB:0];
    end
    if (wr_b2_last) begin
      b2_last_d = wdata_s[`ADDR_MSB:0];
    end
    if (wr_flow) begin
      // Upper bits are dropped here
      mode1_d = wdata_s[`FLOW_B1_LSB +: 2];
      mode2_d = wdata_s[`FLOW_B2_LSB +: 2];
    end
  end

  // End flags: a match in the same cycle as a clear wins
  always @* begin
    flag1_d = flag1_q;
    flag2_d = flag2_q;
    if (wr_flags && !wdata_s[`FLAG_B1_BIT]) begin
      flag1_d = 1'b0;
    end
    if (wr_flags && !wdata_s[`FLAG_B2_BIT]) begin
      flag2_d = 1'b0;
    end
    if (hit1_next) begin
      flag1_d = 1'b1;
    end
    if (hit2_next) begin
      flag2_d = 1'b1;
    end
  end

  // Pointer sequencing
  always @* begin
    ptr_d = ptr_q;
    halted_d = halted_q;
    halt_end_d = halt_end_q;
    release_d = 1'b0;
    load_pend_d = 1'b0;
    load_data_d = load_data_q;
    if (load_pend_q) begin
      // Second cycle of a load: advance is ignored
      ptr_d = load_data_q;
      halted_d = 1'b0;
    end else if (!pointer_load_n_i) begin
      load_data_d = seq_load_data_i;
      load_pend_d = 1'b1;
      halted_d = 1'b0;
    end else if (!restart_buf1_n_i) begin
      ptr_d = b1_first_q;
      halted_d = 1'b0;
    end else if (!restart_buf2_n_i) begin
      ptr_d = b2_first_q;
      halted_d = 1'b0;
    end else if (release_q) begin
      if (advance) begin
        ptr_d = step_addr(halt_end_q, `STEP_TWO);
      end else begin
        // Controller missed the edge: back to stopped
        halted_d = 1'b1;
      end
    end else if (halted_q) begin
      ptr_d = ptr_q;
    end else if ((hit1 || hit2) && (hit_mode == `MODE_STOP)) begin
      halted_d = 1'b1;
      halt_end_d = ptr_q;
      if (advance) begin
        ptr_d = step_addr(ptr_q, `STEP_ONE);
      end
    end else if (advance) begin
      if ((hit1 || hit2) && (hit_mode == `MODE_CHAIN)) begin
        if (hit1 && hit2) begin
          ptr_d = b1_first_q;
        end else if (hit1) begin
          ptr_d = b2_first_q;
        end else begin
          ptr_d = b1_first_q;
        end
      end else begin
        // Reserved modes simply count on
        ptr_d = step_addr(ptr_q, `STEP_ONE);
      end
    end
    // Release acts on the pointer path at once, not on a counted edge
    // Bit 4 passes the host synchroniser, so release lands three edges after the pins
    if (wr_flow && !wdata_s[`FLOW_RELEASE_BIT] && halted_q && !load_pend_q
        && pointer_load_n_i && restart_buf1_n_i && restart_buf2_n_i) begin
      halted_d = 1'b0;
      release_d = 1'b1;
    end
  end

  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      ptr_q <= `RST_POINTER;
      b1_first_q <= `RST_B1_FIRST;
      b1_last_q <= `RST_B1_LAST;
      b2_first_q <= `RST_B2_FIRST;
      b2_last_q <= `RST_B2_LAST;
      mode1_q <= `RST_MODE;
      mode2_q <= `RST_MODE;
      flag1_q <= 1'b0;
      flag2_q <= 1'b0;
      halted_q <= 1'b0;
      halt_end_q <= `RST_POINTER;
      release_q <= 1'b0;
      load_pend_q <= 1'b0;
      load_data_q <= `RST_POINTER;
      wr_seen_q <= 1'b0;
    end else begin
      ptr_q <= ptr_d;
      b1_first_q <= b1_first_d;
      b1_last_q <= b1_last_d;
      b2_first_q <= b2_first_d;
      b2_last_q <= b2_last_d;
      mode1_q <= mode1_d;
      mode2_q <= mode2_d;
      flag1_q <= flag1_d;
      flag2_q <= flag2_d;
      halted_q <= halted_d;
      halt_end_q <= halt_end_d;
      release_q <= release_d;
      load_pend_q <= load_pend_d;
      load_data_q <= load_data_d;
      wr_seen_q <= wr_level;
    end
  end

  // Outputs straight from flops
  // Pointer and flags launch from next values, so they change on one edge
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      pointer_o <= `RST_POINTER;
      buf1_end_flag_n_o <= 1'b1;
      buf2_end_flag_n_o <= 1'b1;
      seq_write_enable_o <= 1'b1;
      host_data_o <= `ALL_ONES_16;
      host_data_oe_o <= 1'b0;
    end else begin
      pointer_o <= ptr_d;
      buf1_end_flag_n_o <= ~flag1_d;
      buf2_end_flag_n_o <= ~flag2_d;
      seq_write_enable_o <= ~halted_d;
      host_data_o <= rdata;
      host_data_oe_o <= rd_level;
    end
  end

endmodule

// ---- src/seq_ptr_defs.vh ----
`ifndef SEQ_PTR_DEFS_VH
`define SEQ_PTR_DEFS_VH

// Command-mode select codes on the three low address lines
`define SEL_B1_FIRST 3'h0
`define SEL_B1_LAST 3'h1
`define SEL_B2_FIRST 3'h2
`define SEL_B2_LAST 3'h3
`define SEL_FLOW 3'h4
`define SEL_FLAGS 3'h5

// Field positions
`define ADDR_MSB 11
`define FLOW_B1_LSB 0
`define FLOW_B2_LSB 2
`define FLOW_RELEASE_BIT 4
`define FLAG_B1_BIT 0
`define FLAG_B2_BIT 1

// Flow mode codes
`define MODE_CHAIN 2'h0
`define MODE_STOP 2'h1

// Readback fill patterns
`define BOUND_READ_TOP 4'he
`define ALL_ONES_16 16'hffff

// Reset values
`define RST_POINTER 12'h000
`define RST_B1_FIRST 12'h000
`define RST_B1_LAST 12'hfff
`define RST_B2_FIRST 12'h000
`define RST_B2_LAST 12'h000
`define RST_MODE 2'h0

// Pointer steps
`define STEP_ONE 2'h1
`define STEP_TWO 2'h2

`endif

// ---- src/pin_sync2.v ----
`timescale 1ns/1ps
module pin_sync2 #(
  parameter WIDTH = 22
) (
  input wire core_clk_i,
  input wire rstn_i,
  input wire [WIDTH-1:0] async_i,
  input wire [WIDTH-1:0] idle_i,
  output reg [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta_q;

  // Idle level is a constant at the top, so reset stays constant
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      meta_q <= idle_i;
      sync_o <= idle_i;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

// ---- src/cmd_readback.v ----
`timescale 1ns/1ps
`include "seq_ptr_defs.vh"
module cmd_readback (
  input wire [2:0] sel_i,
  input wire [11:0] b1_first_i,
  input wire [11:0] b1_last_i,
  input wire [11:0] b2_first_i,
  input wire [11:0] b2_last_i,
  input wire [1:0] mode1_i,
  input wire [1:0] mode2_i,
  input wire halted_i,
  input wire flag1_i,
  input wire flag2_i,
  output reg [15:0] rdata_o
);
  always @* begin
    rdata_o = `ALL_ONES_16;
    case (sel_i)
      `SEL_B1_FIRST: rdata_o = {`BOUND_READ_TOP, b1_first_i};
      `SEL_B1_LAST: rdata_o = {`BOUND_READ_TOP, b1_last_i};
      `SEL_B2_FIRST: rdata_o = {`BOUND_READ_TOP, b2_first_i};
      `SEL_B2_LAST: rdata_o = {`BOUND_READ_TOP, b2_last_i};
      // Bit 4 shows the halted state so software can see a stop
      `SEL_FLOW: rdata_o = {11'h7ff, halted_i, mode2_i, mode1_i};
      `SEL_FLAGS: rdata_o = {14'h3fff, flag2_i, flag1_i};
      default: rdata_o = `ALL_ONES_16;
    endcase
  end
endmodule

// ---- testbench/host_model.sv ----
`timescale 1ns/1ps
module host_model (
  input wire core_clk_i,
  input wire [15:0] host_data_o,
  output logic command_mode_n_o,
  output logic chip_enable_n_o,
  output logic read_write_o,
  output logic [2:0] cmd_addr_o,
  output logic [15:0] host_wdata_o
);
  initial begin
    command_mode_n_o = 1'b1;
    chip_enable_n_o = 1'b0;
    read_write_o = 1'b1;
    cmd_addr_o = 3'h0;
    host_wdata_o = 16'h0000;
  end

  // Pins held four edges: two sync flops plus the output flop, and one edge spare
  task access(input logic rd, input logic [2:0] a, input logic [15:0] d,
              output logic [15:0] q);
    @(negedge core_clk_i);
    command_mode_n_o = 1'b0;
    chip_enable_n_o = 1'b1;
    read_write_o = rd;
    cmd_addr_o = a;
    host_wdata_o = rd ? ~host_wdata_o : d & 16'hefff;
    repeat (4) @(posedge core_clk_i);
    // Read data taken on the falling edge, where it has settled
    @(negedge core_clk_i);
    q = host_data_o;
    command_mode_n_o = 1'b1;
    chip_enable_n_o = 1'b0;
    // Released bus never keeps the last value
    host_wdata_o = ~host_wdata_o;
    // Ends on a falling edge so the next drive stays off the sampling edge
    repeat (3) @(negedge core_clk_i);
  endtask
endmodule

// ---- testbench/ptr_ctrl_asserts.sv ----
`timescale 1ns/1ps
module ptr_ctrl_asserts (
  input wire core_clk_i,
  input wire rstn_i,
  input wire command_mode_n_i,
  input wire chip_enable_n_i,
  input wire read_write_i,
  input wire advance_enable_n_i,
  input wire pointer_load_n_i,
  input wire restart_buf1_n_i,
  input wire restart_buf2_n_i,
  input wire [15:0] host_data_o,
  input wire host_data_oe_o,
  input wire [11:0] pointer_o,
  input wire buf1_end_flag_n_o,
  input wire buf2_end_flag_n_o,
  input wire seq_write_enable_o
);
  default clocking dc @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  wire hold_ok = pointer_load_n_i && restart_buf1_n_i && restart_buf2_n_i;
  wire any_flag = !buf1_end_flag_n_o || !buf2_end_flag_n_o;
  logic [11:0] end_q;

  // End address caught on a stop halt, not on a re-halt after a missed release
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      end_q <= 12'h000;
    end else if ($fell(seq_write_enable_o) && $past(seq_write_enable_o, 2)) begin
      end_q <= $past(pointer_o);
    end
  end

  property p_reset; $rose(rstn_i) |-> pointer_o == 12'h000 && buf1_end_flag_n_o
    && buf2_end_flag_n_o && seq_write_enable_o && !host_data_oe_o; endproperty
  a_reset: assert property (p_reset) else $error("bad state after reset");
  property p_top; host_data_o[15:13] == 3'h7; endproperty
  a_top: assert property (p_top) else $error("read bits 15..13 not high");
  property p_oe; $rose(host_data_oe_o) |-> read_write_i && !command_mode_n_i
    && chip_enable_n_i; endproperty
  a_oe: assert property (p_oe) else $error("data driven without read");
  property p_halt_flag; $fell(seq_write_enable_o) |-> $past(any_flag); endproperty
  a_halt_flag: assert property (p_halt_flag) else $error("halt without flag");
  property p_halt_val; $fell(seq_write_enable_o) |->
    pointer_o == $past(pointer_o) + {11'h000, !$past(advance_enable_n_i)}; endproperty
  a_halt_val: assert property (p_halt_val) else $error("wrong halt address");
  property p_hold; !seq_write_enable_o && hold_ok && $past(pointer_load_n_i)
    |=> $stable(pointer_o); endproperty
  a_hold: assert property (p_hold) else $error("halted pointer moved");
  property p_release; $rose(seq_write_enable_o) && $past(hold_ok)
    && $past(pointer_load_n_i, 2) && hold_ok && !advance_enable_n_i
    |=> pointer_o == end_q + 12'h002; endproperty
  a_release: assert property (p_release) else $error("no step after release");
  property p_rehalt; $rose(seq_write_enable_o) && $past(hold_ok)
    && $past(pointer_load_n_i, 2) && hold_ok && advance_enable_n_i
    |=> !seq_write_enable_o && $stable(pointer_o); endproperty
  a_rehalt: assert property (p_rehalt) else $error("release without advance");
  property p_chain; hold_ok && $past(pointer_load_n_i) && !advance_enable_n_i
    && seq_write_enable_o |=> pointer_o == $past(pointer_o) + 12'h001
    || $past(any_flag); endproperty
  a_chain: assert property (p_chain) else $error("jump without end flag");

  c_halt: cover property ($fell(seq_write_enable_o));
  c_release: cover property ($rose(seq_write_enable_o));
  c_both: cover property ($fell(buf1_end_flag_n_o) && $fell(buf2_end_flag_n_o));
endmodule

bind dual_buffer_pointer_flow_ctrl ptr_ctrl_asserts u_chk (.core_clk_i, .rstn_i,
  .command_mode_n_i, .chip_enable_n_i, .read_write_i, .advance_enable_n_i,
  .pointer_load_n_i, .restart_buf1_n_i, .restart_buf2_n_i, .host_data_o,
  .host_data_oe_o, .pointer_o, .buf1_end_flag_n_o, .buf2_end_flag_n_o,
  .seq_write_enable_o);

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic adv_n = 1'b1;
  logic load_n = 1'b1;
  logic rs1_n = 1'b1;
  logic rs2_n = 1'b1;
  logic [11:0] ld_data = 12'h000;
  logic [15:0] rd;
  wire cmd_n, ce_n, rw, oe, f1_n, f2_n, wen;
  wire [2:0] sel;
  wire [15:0] hd_i, hd_o;
  wire [11:0] ptr;
  // Pointer, both flags and write enable in one word
  wire [15:0] obs = {ptr, f1_n, f2_n, wen, 1'b0};
  int errors = 0;
  int checks_done = 0;
  // {write, select}, write data, expected read
  logic [35:0] rows [0:11] = '{36'h0_0000_e000, 36'h1_0000_efff, 36'h2_0000_e000,
    36'h3_0000_e000, 36'h4_0000_ffe0, 36'h8_0008_e008, 36'h9_0010_e010,
    36'ha_0020_e020, 36'hb_0030_e030, 36'hc_ffe4_ffe4, 36'he_0000_ffff,
    36'hf_5555_ffff};

  always #50 core_clk_i = ~core_clk_i;

  host_model u_host (.core_clk_i, .host_data_o(hd_o), .command_mode_n_o(cmd_n),
    .chip_enable_n_o(ce_n), .read_write_o(rw), .cmd_addr_o(sel), .host_wdata_o(hd_i));
  dual_buffer_pointer_flow_ctrl u_dut (.core_clk_i, .rstn_i, .command_mode_n_i(cmd_n),
    .chip_enable_n_i(ce_n), .read_write_i(rw), .cmd_addr_i(sel), .host_data_i(hd_i),
    .host_data_o(hd_o), .host_data_oe_o(oe), .advance_enable_n_i(adv_n),
    .pointer_load_n_i(load_n), .restart_buf1_n_i(rs1_n), .restart_buf2_n_i(rs2_n),
    .seq_load_data_i(ld_data), .pointer_o(ptr), .buf1_end_flag_n_o(f1_n),
    .buf2_end_flag_n_o(f2_n), .seq_write_enable_o(wen));

  task wrap_up;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task wait_obs(input logic [15:0] m, input logic [15:0] v);
    int k;
    for (k = 0; k < 200 && (obs & m) !== v; k++) @(negedge core_clk_i);
    if ((obs & m) !== v) begin
      errors++;
      wrap_up;
    end
  endtask
  task hw(input logic [2:0] a, input logic [15:0] d);
    u_host.access(1'b0, a, d, rd);
  endtask
  task hr(input logic [2:0] a, input logic [15:0] e);
    u_host.access(1'b1, a, 16'h0000, rd);
    chk(rd, e);
  endtask
  task pulse_restart(input logic two);
    if (two) rs2_n = 1'b0;
    else rs1_n = 1'b0;
    @(negedge core_clk_i);
    rs1_n = 1'b1;
    rs2_n = 1'b1;
  endtask

  initial begin
    repeat (20) @(negedge core_clk_i);
    rstn_i = 1'b1;
    chk(obs, 16'h000e);
    foreach (rows[i]) begin
      if (rows[i][35]) hw(rows[i][34:32], rows[i][31:16]);
      hr(rows[i][34:32], rows[i][15:0]);
    end
    // Buffer two end resets onto the pointer, so its flag may be set
    hw(3'h5, 16'h0000);
    hr(3'h5, 16'hfffc);
    pulse_restart(1'b0);
    chk(obs, 16'h008e);
    adv_n = 1'b0;
    wait_obs(16'hfff0, 16'h0100);
    chk(obs, 16'h0106);
    @(negedge core_clk_i);
    chk(obs, 16'h0206);
    wait_obs(16'hfff0, 16'h0300);
    @(negedge core_clk_i);
    chk(obs, 16'h0310);
    repeat (3) @(negedge core_clk_i);
    chk(obs, 16'h0310);
    hw(3'h5, 16'h0002);
    chk(obs, 16'h0318);
    hr(3'h5, 16'hfffe);
    hr(3'h4, 16'hfff4);
    fork
      hw(3'h4, 16'h0004);
      begin
        wait_obs(16'h0002, 16'h0002);
        @(negedge core_clk_i);
        chk(obs, 16'h032a);
      end
    join
    adv_n = 1'b1;
    hw(3'h5, 16'h0000);
    hr(3'h5, 16'hfffc);
    pulse_restart(1'b1);
    chk(obs, 16'h020e);
    adv_n = 1'b0;
    wait_obs(16'hfff0, 16'h0300);
    adv_n = 1'b1;
    @(negedge core_clk_i);
    chk(obs, 16'h0308);
    hw(3'h4, 16'h0004);
    chk(obs, 16'h0308);
    pulse_restart(1'b0);
    chk(obs, 16'h008a);
    hw(3'h1, 16'h0030);
    hw(3'h5, 16'h0000);
    hw(3'h4, 16'h0000);
    ld_data = 12'h02e;
    load_n = 1'b0;
    @(negedge core_clk_i);
    load_n = 1'b1;
    @(negedge core_clk_i);
    chk(obs, 16'h02ee);
    adv_n = 1'b0;
    wait_obs(16'hfff0, 16'h0300);
    chk(obs, 16'h0302);
    @(negedge core_clk_i);
    chk(obs, 16'h0082);
    adv_n = 1'b1;
    rstn_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    rstn_i = 1'b1;
    chk(obs, 16'h000e);
    hr(3'h1, 16'hefff);
    wrap_up;
  end
endmodule
